// ==== rtl/emm_top.sv ====
// Explicit request interpreter serving table and variable memories.
// Assumes byte streams synchronous to core_clk_in, one message at a time.
`timescale 1ns/100ps
`default_nettype none
`include "emm_map.svh"

module emm_top
(
    // Clock and reset
    input  wire logic              core_clk_in,
    input  wire logic              rst_n_in,
    // Request byte stream
    input  wire emm_pkg::emm_byte_s req_in,
    input  wire logic              req_valid_in,
    output logic                   req_ready_out,
    // Response byte stream
    output emm_pkg::emm_byte_s     rsp_out,
    output logic                   rsp_valid_out,
    input  wire logic              rsp_ready_in,
    // Local variable memory writes
    input  wire emm_pkg::emm_vwr_s var_wr_in
);
    import emm_pkg::*;

    // =================================================================
    // Decode helpers
    function automatic logic emm_svc_ok(input logic [7:0] s);
        return s inside {`EMM_SVC_TBL_RD3, `EMM_SVC_VAR_RD3,
                         `EMM_SVC_VAR_RD1, `EMM_SVC_TBL_WR3};
    endfunction : emm_svc_ok

    function automatic logic emm_is_tbl(input logic [7:0] s);
        return s == `EMM_SVC_TBL_RD3 || s == `EMM_SVC_TBL_WR3;
    endfunction : emm_is_tbl

    function automatic logic emm_is_one(input logic [7:0] s);
        return s == `EMM_SVC_VAR_RD1;
    endfunction : emm_is_one

    function automatic logic [15:0] emm_start(input logic [7:0] s,
                                              input logic [15:0] a);
        return emm_is_tbl(s) ? a : {8'h00, a[7:0]};
    endfunction : emm_start

    function automatic logic [15:0] emm_max(input logic [7:0] s);
        return emm_is_tbl(s) ? `EMM_TBL_MAX : `EMM_VAR_MAX;
    endfunction : emm_max

    // Integer part only; sign dropped, no two's complement
    function automatic logic [15:0] emm_int_part(input emm_elem_t e);
        logic [23:0] acc;
        logic [3:0]  dec;
        logic [3:0]  dig;
        acc = 24'h000000;
        dec = e[`EMM_DEC_LSB +: 4];
        dig = 4'h0;
        for (int i = `EMM_DIGITS - 1; i >= 0; i--)
        begin
            if (i < `EMM_W1_DIGITS)
                dig = e[`EMM_W1_LSB + 4 * i +: 4];
            else
                dig = e[`EMM_W2_LSB + 4 * (i - `EMM_W1_DIGITS) +: 4];
            if (i >= int'(dec))
                acc = 24'(acc * 24'h00000a + 24'(dig));
        end
        return (acc > `EMM_SAT) ? 16'hffff : acc[15:0];
    endfunction : emm_int_part

    // =================================================================
    // State
    emm_state_e  state;
    emm_state_e  next_state;
    logic [3:0]  hdr_idx;
    logic [7:0]  svc;
    logic [15:0] cls;
    logic [15:0] inst;
    logic [15:0] addr;
    logic [7:0]  cnt;
    logic        hdr_ended;
    logic        hdr_short;
    logic [7:0]  err_code;
    logic [7:0]  check_err;
    logic [12:0] elem_addr;
    logic [7:0]  elem_left;
    logic [2:0]  byte_idx;
    logic [2:0]  last_byte;
    emm_elem_t   wbuf;
    emm_elem_t   rd_elem;
    emm_elem_t   rd_shift;
    logic [15:0] start_a;
    logic [16:0] end_a;
    logic [15:0] reply_n;
    logic        req_take;
    logic        slot_free;
    logic        err_flag;
    logic        elem_done;
    logic        emit;
    emm_byte_s   emit_byte;

    // Memories are not reset; software owns their contents
    emm_elem_t   tbl_mem [0:`EMM_TBL_DEPTH-1];
    emm_elem_t   var_mem [0:`EMM_VAR_DEPTH-1];

    assign req_take  = req_valid_in && req_ready_out;
    assign slot_free = !rsp_valid_out || rsp_ready_in;
    assign err_flag  = err_code != `EMM_ERR_NONE;
    assign elem_done = byte_idx == `EMM_LAST3;
    assign last_byte = emm_is_one(svc) ? `EMM_LAST1 : `EMM_LAST3;
    assign rd_shift  = rd_elem << {byte_idx, 3'h0};

    // =================================================================
    // Request checks, in priority order
    always_comb
    begin
        start_a   = emm_start(svc, addr);
        end_a     = 17'(start_a) + 17'(cnt) - 17'h00001;
        reply_n   = 16'(cnt) * (emm_is_one(svc) ? `EMM_BYTES1 : `EMM_BYTES3);
        check_err = `EMM_ERR_NONE;
        if (!emm_svc_ok(svc))
            check_err = `EMM_ERR_NOSVC;
        else if (hdr_short)
            check_err = `EMM_ERR_SHORT;
        else if (cls != `EMM_CLASS_ID || inst != `EMM_INST_ID)
            check_err = `EMM_ERR_NOOBJ;
        else if (cnt == 8'h00)
            check_err = `EMM_ERR_ATTR;
        else if (end_a > 17'(emm_max(svc)))
            check_err = `EMM_ERR_PARAM;
        else if (svc != `EMM_SVC_TBL_WR3 && reply_n > `EMM_RSP_BUF)
            check_err = `EMM_ERR_REPLY;
        else if (svc != `EMM_SVC_TBL_WR3 && !hdr_ended)
            check_err = `EMM_ERR_LONG;
        else if (svc == `EMM_SVC_TBL_WR3 && hdr_ended)
            check_err = `EMM_ERR_SHORT;
    end

    // =================================================================
    // Sequencer
    always_comb
    begin
        next_state = state;
        unique case (state)
            ST_HDR:
                if (req_take && (req_in.last || hdr_idx == `EMM_HB_LEN_L))
                    next_state = ST_CHECK;
            ST_CHECK:
                if (check_err != `EMM_ERR_NONE)
                    next_state = hdr_ended ? ST_SVC : ST_DRAIN;
                else if (svc == `EMM_SVC_TBL_WR3)
                    next_state = ST_WDATA;
                else
                    next_state = ST_SVC;
            ST_WDATA:
                if (req_take && req_in.last)
                    next_state = ST_SVC;
                else if (req_take && elem_done && elem_left == 8'h01)
                    next_state = ST_DRAIN;
            ST_DRAIN:
                if (req_take && req_in.last)
                    next_state = ST_SVC;
            ST_SVC:
                if (slot_free)
                    next_state = err_flag ? ST_ERR :
                        (svc == `EMM_SVC_TBL_WR3 ? ST_HDR : ST_FETCH);
            ST_ERR:
                if (slot_free)
                    next_state = ST_HDR;
            ST_FETCH:
                next_state = ST_DATA;
            ST_DATA:
                if (slot_free && byte_idx == last_byte)
                    next_state = (elem_left == 8'h01) ? ST_HDR : ST_FETCH;
        endcase
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state         <= ST_HDR;
            req_ready_out <= 1'b1;
        end
        else
        begin
            state         <= next_state;
            req_ready_out <= next_state inside {ST_HDR, ST_WDATA, ST_DRAIN};
        end
    end

    // =================================================================
    // Header capture
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            hdr_idx   <= `EMM_HB_SVC;
            svc       <= 8'h00;
            cls       <= 16'h0000;
            inst      <= 16'h0000;
            addr      <= 16'h0000;
            cnt       <= 8'h00;
            hdr_ended <= 1'b0;
            hdr_short <= 1'b0;
        end
        else if (state != ST_HDR)
            hdr_idx <= `EMM_HB_SVC;
        else if (req_take)
        begin
            hdr_idx   <= hdr_idx + 4'h1;
            hdr_ended <= req_in.last;
            hdr_short <= req_in.last && hdr_idx != `EMM_HB_LEN_L;
            case (hdr_idx)
                `EMM_HB_SVC:   svc        <= req_in.data;
                `EMM_HB_CLS_H: cls[15:8]  <= req_in.data;
                `EMM_HB_CLS_L: cls[7:0]   <= req_in.data;
                `EMM_HB_INS_H: inst[15:8] <= req_in.data;
                `EMM_HB_INS_L: inst[7:0]  <= req_in.data;
                `EMM_HB_ADR_H: addr[15:8] <= req_in.data;
                `EMM_HB_ADR_L: addr[7:0]  <= req_in.data;
                `EMM_HB_LEN_L: cnt        <= req_in.data;
                default:       ;
            endcase
        end
    end

    // =================================================================
    // Error code; cleared only while idle, after the answer left
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            err_code <= `EMM_ERR_NONE;
        else if (state == ST_HDR)
            err_code <= `EMM_ERR_NONE;
        else if (state == ST_CHECK)
            err_code <= check_err;
        else if (state == ST_WDATA && req_take)
        begin
            if (req_in.last && !(elem_done && elem_left == 8'h01))
                err_code <= `EMM_ERR_SHORT;
            else if (!req_in.last && elem_done && elem_left == 8'h01)
                err_code <= `EMM_ERR_LONG;
        end
    end

    // =================================================================
    // Element walk
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            elem_addr <= 13'h0000;
            elem_left <= 8'h00;
            byte_idx  <= 3'h0;
            wbuf      <= '0;
        end
        else if (state == ST_CHECK)
        begin
            elem_addr <= start_a[12:0];
            elem_left <= cnt;
            byte_idx  <= 3'h0;
        end
        else if (state == ST_WDATA && req_take)
        begin
            wbuf <= {wbuf[39:0], req_in.data};
            if (elem_done)
            begin
                byte_idx  <= 3'h0;
                elem_addr <= elem_addr + 13'h0001;
                elem_left <= elem_left - 8'h01;
            end
            else
                byte_idx <= byte_idx + 3'h1;
        end
        else if (state == ST_DATA && slot_free)
        begin
            if (byte_idx == last_byte)
            begin
                byte_idx  <= 3'h0;
                elem_addr <= elem_addr + 13'h0001;
                elem_left <= elem_left - 8'h01;
            end
            else
                byte_idx <= byte_idx + 3'h1;
        end
    end

    // =================================================================
    // Memories; a write lands element by element as it completes
    always_ff @(posedge core_clk_in)
    begin
        if (state == ST_WDATA && req_take && elem_done)
            tbl_mem[elem_addr] <= {wbuf[39:0], req_in.data};
    end

    always_ff @(posedge core_clk_in)
    begin
        if (var_wr_in.en)
            var_mem[var_wr_in.addr] <= var_wr_in.data;
    end

    always_ff @(posedge core_clk_in)
    begin
        if (state == ST_FETCH)
        begin
            if (emm_is_tbl(svc))
                rd_elem <= tbl_mem[elem_addr];
            else if (emm_is_one(svc))
                rd_elem <= {emm_int_part(var_mem[elem_addr[7:0]]), 32'h0};
            else
                rd_elem <= var_mem[elem_addr[7:0]];
        end
    end

    // =================================================================
    // Response output stage; one register, stalls on the master
    always_comb
    begin
        emit      = 1'b1;
        emit_byte = '0;
        unique case (state)
            ST_SVC:
            begin
                emit_byte.data = err_flag ? `EMM_SVC_ERR : (svc | `EMM_RSP_BIT);
                emit_byte.last = !err_flag && svc == `EMM_SVC_TBL_WR3;
            end
            ST_ERR:
            begin
                emit_byte.data = err_code;
                emit_byte.last = 1'b1;
            end
            ST_DATA:
            begin
                emit_byte.data = rd_shift[47:40];
                emit_byte.last = elem_left == 8'h01 && byte_idx == last_byte;
            end
            ST_HDR, ST_CHECK, ST_WDATA, ST_DRAIN, ST_FETCH:
                emit = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rsp_valid_out <= 1'b0;
            rsp_out       <= '0;
        end
        else if (slot_free)
        begin
            rsp_valid_out <= emit;
            rsp_out       <= emit_byte;
        end
    end

    // =================================================================
    // Checks
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_svc_out;
        state == ST_SVC && slot_free;
    endsequence

    sequence s_short_hdr;
        state == ST_HDR && req_take && req_in.last && emm_svc_ok(svc)
            && hdr_idx != `EMM_HB_SVC && hdr_idx != `EMM_HB_LEN_L;
    endsequence

    property p_norm_svc;
        s_svc_out ##0 !err_flag |=> rsp_valid_out && rsp_out.data == (svc | `EMM_RSP_BIT);
    endproperty
    a_norm_svc: assert property (p_norm_svc)
        else $error("normal service code not echoed with top bit");

    property p_err_svc;
        s_svc_out ##0 err_flag |=> rsp_out.data == `EMM_SVC_ERR && state == ST_ERR;
    endproperty
    a_err_svc: assert property (p_err_svc)
        else $error("error response service code wrong");

    property p_unsup;
        state == ST_CHECK && !emm_svc_ok(svc) |=> err_code == `EMM_ERR_NOSVC;
    endproperty
    a_unsup: assert property (p_unsup)
        else $error("unsupported service not flagged");

    property p_short;
        s_short_hdr |=> ##1 err_code == `EMM_ERR_SHORT;
    endproperty
    a_short: assert property (p_short)
        else $error("short header not flagged");

    property p_range;
        state == ST_CHECK && emm_svc_ok(svc) && !hdr_short && cnt != 8'h00
            && cls == `EMM_CLASS_ID && inst == `EMM_INST_ID
            && 17'(emm_start(svc, addr)) + 17'(cnt) > 17'(emm_max(svc)) + 17'h00001
            |=> err_code == `EMM_ERR_PARAM;
    endproperty
    a_range: assert property (p_range)
        else $error("out of range request accepted");

    property p_var_addr;
        state == ST_CHECK && !emm_is_tbl(svc) |=> elem_addr == {5'h00, $past(addr[7:0])};
    endproperty
    a_var_addr: assert property (p_var_addr)
        else $error("variable address used high byte");

    property p_word_order;
        state == ST_DATA && slot_free && byte_idx == 3'h0 |=> rsp_out.data == rd_elem[47:40];
    endproperty
    a_word_order: assert property (p_word_order)
        else $error("word not sent high byte first");

    property p_elem3;
        state == ST_DATA && slot_free && !emm_is_one(svc) && byte_idx == `EMM_LAST3
            |=> byte_idx == 3'h0 && state inside {ST_FETCH, ST_HDR};
    endproperty
    a_elem3: assert property (p_elem3)
        else $error("three-word element not six bytes");

    property p_write_end;
        state == ST_WDATA && req_take && req_in.last && elem_done && elem_left == 8'h01
            |=> state == ST_SVC && !err_flag;
    endproperty
    a_write_end: assert property (p_write_end)
        else $error("complete table write not answered normally");

endmodule : emm_top

`default_nettype wire

// ==== rtl/emm_map.svh ====
// Constants of the explicit message memory access block.
// Assumes it is included by the package user and the top module only.
`ifndef EMM_MAP_SVH
`define EMM_MAP_SVH

// =====================================================================
// Service and object codes
`define EMM_SVC_TBL_RD3 8'h32
`define EMM_SVC_VAR_RD3 8'h33
`define EMM_SVC_VAR_RD1 8'h34
`define EMM_SVC_TBL_WR3 8'h35
`define EMM_RSP_BIT     8'h80
`define EMM_SVC_ERR     8'h94
`define EMM_CLASS_ID    16'h008a
`define EMM_INST_ID     16'h0001

// =====================================================================
// General error codes
`define EMM_ERR_NONE    8'h00
`define EMM_ERR_NOSVC   8'h08
`define EMM_ERR_ATTR    8'h09
`define EMM_ERR_REPLY   8'h11
`define EMM_ERR_SHORT   8'h13
`define EMM_ERR_LONG    8'h15
`define EMM_ERR_NOOBJ   8'h16
`define EMM_ERR_PARAM   8'h20

// =====================================================================
// Limits and sizes
`define EMM_TBL_MAX     16'h1f3f
`define EMM_VAR_MAX     16'h00fa
`define EMM_TBL_DEPTH   8000
`define EMM_VAR_DEPTH   251
`define EMM_RSP_BUF     16'h00ee
`define EMM_BYTES3      16'h0006
`define EMM_BYTES1      16'h0002
`define EMM_LAST3       3'h5
`define EMM_LAST1       3'h1

// =====================================================================
// Header byte positions in a request
`define EMM_HB_SVC      4'h0
`define EMM_HB_CLS_H    4'h1
`define EMM_HB_CLS_L    4'h2
`define EMM_HB_INS_H    4'h3
`define EMM_HB_INS_L    4'h4
`define EMM_HB_ADR_H    4'h5
`define EMM_HB_ADR_L    4'h6
`define EMM_HB_LEN_H    4'h7
`define EMM_HB_LEN_L    4'h8

// =====================================================================
// Three-word element layout {decimals, low digits, sign and high digits}
`define EMM_DEC_LSB     32
`define EMM_W1_LSB      16
`define EMM_W2_LSB      0
`define EMM_W1_DIGITS   4
`define EMM_DIGITS      7
`define EMM_SAT         24'h00ffff

`endif

// ==== rtl/emm_pkg.sv ====
// Types shared by the explicit message memory access block.
// Assumes the constants header is included alongside.
package emm_pkg;

    // One byte of a message stream, with its end marker
    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } emm_byte_s;

    typedef logic [47:0] emm_elem_t;

    // Local write port into the variable memory
    typedef struct packed {
        logic       en;
        logic [7:0] addr;
        emm_elem_t  data;
    } emm_vwr_s;

    typedef enum logic [2:0] {
        ST_HDR,
        ST_CHECK,
        ST_WDATA,
        ST_DRAIN,
        ST_SVC,
        ST_ERR,
        ST_FETCH,
        ST_DATA
    } emm_state_e;

endpackage : emm_pkg

// ==== dv/emm_master_model.sv ====
// Fieldbus master model: sends request messages, takes response bytes.
// Assumes the bench calls send_msg and reads rx_q once rx_done is set.
`timescale 1ns/100ps
`default_nettype none

module emm_master_model
(
    // Clock and reset
    input  wire logic               core_clk_in,
    input  wire logic               rst_n_in,
    // Request stream
    output emm_pkg::emm_byte_s      req_out,
    output logic                    req_valid_out,
    input  wire logic               req_ready_in,
    // Response stream
    input  wire emm_pkg::emm_byte_s rsp_in,
    input  wire logic               rsp_valid_in,
    output logic                    rsp_ready_out
);
    import emm_pkg::*;

    logic [7:0] rx_q[$];
    logic       rx_done;
    logic       slow;
    logic [1:0] ph;

    initial
    begin
        req_out       = '0;
        req_valid_out = 1'b0;
        rsp_ready_out = 1'b1;
        rx_done       = 1'b0;
        slow          = 1'b0;
        ph            = 2'h0;
    end

    // =====================================
    // Response side, stalls when slow
    always @(negedge core_clk_in)
    begin
        rsp_ready_out = !slow || (ph == 2'h0);
        ph            = (ph == 2'h2) ? 2'h0 : ph + 2'h1;
    end

    always @(posedge core_clk_in)
    begin
        if (rst_n_in && rsp_valid_in && rsp_ready_out)
        begin
            rx_q.push_back(rsp_in.data);
            if (rsp_in.last)
                rx_done = 1'b1;
        end
    end

    // =====================================
    // Request side, held until taken
    task automatic send_msg(input logic [7:0] q[$]);
        for (int i = 0; i < q.size(); i++)
        begin
            @(negedge core_clk_in);
            req_valid_out = 1'b1;
            req_out.data  = q[i];
            req_out.last  = (i == q.size() - 1);
            do
                @(posedge core_clk_in);
            while (!req_ready_in);
        end
        @(negedge core_clk_in);
        req_valid_out = 1'b0;
        // Released bus must not show a stale byte
        req_out.data  = ~req_out.data;
    endtask : send_msg

endmodule : emm_master_model
`default_nettype wire

// ==== dv/explicit_message_memory_access_bench.sv ====
// Self-checking bench for the explicit request interpreter.
// Assumes the master model drives requests and collects responses.
`timescale 1ns/100ps
`default_nettype none

module explicit_message_memory_access_bench;
    import emm_pkg::*;

    logic       core_clk_in;
    logic       rst_n_in;
    emm_byte_s  req;
    logic       req_valid;
    logic       req_ready;
    emm_byte_s  rsp;
    logic       rsp_valid;
    logic       rsp_ready;
    emm_vwr_s   var_wr;
    logic [7:0] rq[$];
    logic [7:0] ex[$];
    emm_elem_t  vv[119];
    int         err_total = 0;
    int         num_checks = 0;
    int         seed = 32'hdc10;
    int         cyc = 0;

    emm_top dut_u
    (
        .core_clk_in   (core_clk_in),
        .rst_n_in      (rst_n_in),
        .req_in        (req),
        .req_valid_in  (req_valid),
        .req_ready_out (req_ready),
        .rsp_out       (rsp),
        .rsp_valid_out (rsp_valid),
        .rsp_ready_in  (rsp_ready),
        .var_wr_in     (var_wr)
    );

    emm_master_model m_u
    (
        .core_clk_in   (core_clk_in),
        .rst_n_in      (rst_n_in),
        .req_out       (req),
        .req_valid_out (req_valid),
        .req_ready_in  (req_ready),
        .rsp_in        (rsp),
        .rsp_valid_in  (rsp_valid),
        .rsp_ready_out (rsp_ready)
    );

    // =====================================
    // Clock, timeout and verdict
    initial
    begin
        core_clk_in = 1'b0;
        forever #5 core_clk_in = ~core_clk_in;
    end

    always @(posedge core_clk_in)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fail("timeout");
            stop_test();
        end
    end

    task automatic stop_test();
        if (err_total == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : stop_test

    task automatic fail(input string s);
        err_total++;
        $display("[FAIL] %0t %s", $time, s);
    endtask : fail

    // =====================================
    // Stimulus and expectation helpers
    function automatic int rnd(input int n);
        return ($random(seed) & 32'h7fffffff) % n;
    endfunction : rnd

    function automatic emm_elem_t rnd_elem();
        emm_elem_t e;
        e = '0;
        for (int k = 0; k < 8; k++)
            e[k*4+:4] = 4'(rnd(10));
        e[15:12] = 4'(rnd(2) << 3);
        e[35:32] = 4'(rnd(8));
        return e;
    endfunction : rnd_elem

    // Integer part of the decimal value, sign dropped, saturated
    function automatic logic [15:0] one_word(input emm_elem_t e);
        longint v;
        v = 0;
        for (int k = 2; k >= 0; k--)
            v = v * 10 + e[k*4+:4];
        for (int k = 7; k >= 4; k--)
            v = v * 10 + e[k*4+:4];
        for (int k = 0; k < e[35:32]; k++)
            v = v / 10;
        return (v > 65535) ? 16'hffff : v[15:0];
    endfunction : one_word

    task automatic push6(ref logic [7:0] q[$], input emm_elem_t e);
        for (int k = 5; k >= 0; k--)
            q.push_back(e[k*8+:8]);
    endtask : push6

    task automatic hdr(input logic [7:0] svc, input logic [15:0] cls, ins, adr, len);
        rq = {svc, cls[15:8], cls[7:0], ins[15:8], ins[7:0],
              adr[15:8], adr[7:0], len[15:8], len[7:0]};
        ex.delete();
    endtask : hdr

    task automatic var_put(input logic [7:0] a, input emm_elem_t e);
        @(negedge core_clk_in);
        var_wr = '{en: 1'b1, addr: a, data: e};
        @(negedge core_clk_in);
        var_wr.en = 1'b0;
    endtask : var_put

    task automatic check_rsp();
        num_checks++;
        if (!m_u.rx_done)
            fail("response never ended");
        if (m_u.rx_q.size() != ex.size())
            fail("response length");
        else
            foreach (ex[i])
                if (m_u.rx_q[i] !== ex[i])
                    fail("response byte");
    endtask : check_rsp

    task automatic txn();
        int w;
        m_u.rx_q.delete();
        m_u.rx_done = 1'b0;
        m_u.slow = 1'(rnd(2));
        m_u.send_msg(rq);
        w = 0;
        while (!m_u.rx_done && w < 2000)
        begin
            @(posedge core_clk_in);
            w++;
        end
        check_rsp();
    endtask : txn

    task automatic err_case(input logic [7:0] svc, input logic [15:0] cls, ins, adr, len,
                            input int nx, input logic [7:0] code);
        hdr(svc, cls, ins, adr, len);
        repeat (nx) rq.push_back(8'(rnd(256)));
        ex = {8'h94, code};
        txn();
    endtask : err_case

    // =====================================
    // Main sequence
    initial
    begin
        emm_elem_t   e;
        logic [15:0] a;
        logic [15:0] w;
        rst_n_in = 1'b0;
        var_wr   = '0;
        repeat (5) @(posedge core_clk_in);
        @(negedge core_clk_in);
        rst_n_in = 1'b1;
        // Table write then read back, top address first
        for (int n = 0; n < 4; n++)
        begin
            e = rnd_elem();
            e[47:40] = 8'(rnd(256));
            a = (n == 0) ? 16'h1f3f : 16'(rnd(8000));
            hdr(8'h35, 16'h008a, 16'h0001, a, {8'(rnd(256)), 8'h01});
            push6(rq, e);
            ex = {8'hb5};
            txn();
            hdr(8'h32, 16'h008a, 16'h0001, a, {8'(rnd(256)), 8'h01});
            ex = {8'hb2};
            push6(ex, e);
            txn();
        end
        // Error responses, at least one per cause
        err_case(8'h36, 16'h008a, 16'h0001, 16'h0000, 16'h0001, 0, 8'h08);
        err_case(8'h05, 16'h008a, 16'h0001, 16'h0000, 16'h0001, 0, 8'h08);
        err_case(8'h32, 16'h008b, 16'h0001, 16'h0000, 16'h0001, 0, 8'h16);
        err_case(8'h34, 16'h008a, 16'h0002, 16'h0000, 16'h0001, 0, 8'h16);
        err_case(8'h32, 16'h008a, 16'h0001, 16'h0000, 16'h5500, 0, 8'h09);
        err_case(8'h32, 16'h008a, 16'h0001, 16'h1f3f, 16'h0002, 0, 8'h20);
        err_case(8'h33, 16'h008a, 16'h0001, 16'h12fb, 16'h0001, 0, 8'h20);
        err_case(8'h34, 16'h008a, 16'h0001, 16'h0083, 16'h0078, 0, 8'h11);
        err_case(8'h32, 16'h008a, 16'h0001, 16'h0000, 16'h0028, 0, 8'h11);
        err_case(8'h32, 16'h008a, 16'h0001, 16'h0000, 16'h0001, 1, 8'h15);
        err_case(8'h35, 16'h008a, 16'h0001, 16'h0000, 16'h0001, 0, 8'h13);
        err_case(8'h35, 16'h008a, 16'h0001, 16'h0010, 16'h0001, 7, 8'h15);
        err_case(8'h35, 16'h008a, 16'h0001, 16'h0020, 16'h0002, 6, 8'h13);
        hdr(8'h32, 16'h008a, 16'h0001, 16'h0000, 16'h0001);
        rq = rq[0:4];
        ex = {8'h94, 8'h13};
        txn();
        // Variable memory, largest one-word read ending at the top
        foreach (vv[i])
        begin
            vv[i] = (i == 118) ? 48'h0000_9999_0999 : rnd_elem();
            var_put(8'(8'h84 + i), vv[i]);
        end
        hdr(8'h33, 16'h008a, 16'h0001, {8'(rnd(256)), 8'hf8}, {8'(rnd(256)), 8'h03});
        ex = {8'hb3};
        for (int i = 116; i < 119; i++)
            push6(ex, vv[i]);
        txn();
        hdr(8'h34, 16'h008a, 16'h0001, {8'(rnd(256)), 8'h84}, 16'h0077);
        ex = {8'hb4};
        foreach (vv[i])
        begin
            w = one_word(vv[i]);
            ex.push_back(w[15:8]);
            ex.push_back(w[7:0]);
        end
        txn();
        stop_test();
    end

endmodule : explicit_message_memory_access_bench
`default_nettype wire
